/* File: inc/power_policy_pkg.sv */
// constants, types and register map of the host power policy block
// assumes a 50 MHz core clock and a v1..v3 register set selected by parameter
package power_policy_pkg;
	// ----------------------------------------------------------------
	// register offsets, set version 3 unless marked
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_SHDN      = 8'h0a; // shutdown battery threshold
	localparam logic [7:0] OFS_BOOT      = 8'h0c; // boot battery threshold
	localparam logic [7:0] OFS_VMAX      = 8'h0e; // external supply limit
	localparam logic [7:0] OFS_ADC_OFS   = 8'h10; // adc offset calibration
	localparam logic [7:0] OFS_DELAY     = 8'h12; // poweroff tick delay
	localparam logic [7:0] OFS_AUTO      = 8'h14; // automatic power on
	localparam logic [7:0] OFS_WAKE      = 8'h16; // wakeup minutes
	localparam logic [7:0] OFS_DELAY_V2  = 8'h10;
	localparam logic [7:0] OFS_AUTO_V2   = 8'h12;
	localparam logic [7:0] OFS_WAKE_V2   = 8'h14;
	localparam logic [7:0] OFS_AUTO_V1   = 8'h10;
	localparam logic [7:0] OFS_WAKE_V1   = 8'h12;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_SHDN     = 16'h025c; // 604 counts
	localparam logic [15:0] RST_BOOT     = 16'h0285; // 645 counts
	localparam logic [15:0] RST_VMAX     = 16'h02cd; // 717 counts
	localparam logic [15:0] RST_ADC_OFS  = 16'h0000;
	localparam logic [15:0] RST_DELAY    = 16'h0041; // 65 ticks
	localparam logic [15:0] RST_AUTO     = 16'h0000;
	localparam logic [15:0] RST_WAKE     = 16'h0000;
	localparam logic [6:0]  RST_DEV_ADDR = 7'h43;
	localparam logic [7:0]  AUTO_OFF     = 8'h00;
	localparam logic [7:0]  AUTO_VBAT    = 8'h01;
	localparam logic [7:0]  AUTO_SMART   = 8'h02;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		R_SHDN, R_BOOT, R_VMAX, R_ADC_OFS, R_DELAY, R_AUTO, R_WAKE, R_NONE
	} reg_id_t;
	typedef struct packed {
		reg_id_t id; // which setting
		logic    hi; // upper byte selected
	} reg_sel_t;
	typedef struct packed {
		logic [7:0] addr; // byte address
		logic [7:0] data; // written byte
	} byte_wr_t;
endpackage : power_policy_pkg

/* File: verilog/i2c_byte_target.sv */
// i2c target: address match, byte pointer, sequential reads and writes
// assumes scl and sda already synchronous to the core clock
`timescale 1ns/1ps
module i2c_byte_target (
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	input  wire logic [6:0]                 i_dev_addr,
	input  wire logic                       i_scl,
	input  wire logic                       i_sda,
	output logic                            o_sda_oe,
	output logic [7:0]                      o_ptr,
	input  wire logic [7:0]                 i_rd_data,
	output logic                            o_wr,
	output power_policy_pkg::byte_wr_t      o_wr_byte
);
	import power_policy_pkg::*;
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_WRB, S_RDB, S_MACK} tgt_state_t;
	tgt_state_t state_q;  // protocol phase
	logic       scl_q;    // scl one cycle ago
	logic       sda_q;    // sda one cycle ago
	logic [7:0] sh_q;     // shift register
	logic [3:0] cnt_q;    // bits seen in byte
	logic       rw_q;     // read transfer
	logic       first_q;  // next write byte is pointer
	logic       nack_q;   // master refused more data
	// ----------------------------------------------------------------
	// bus event decode
	// ----------------------------------------------------------------
	wire start_ev = i_scl & scl_q & sda_q & ~i_sda;
	wire stop_ev  = i_scl & scl_q & ~sda_q & i_sda;
	wire rise_ev  = i_scl & ~scl_q;
	wire fall_ev  = ~i_scl & scl_q;
	wire byte_end = fall_ev & (cnt_q == 4'd8);
	wire addr_hit = (sh_q[7:1] == i_dev_addr);
	// ----------------------------------------------------------------
	// protocol engine
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= S_IDLE;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sh_q <= 8'h00;
			cnt_q <= 4'h0;
			rw_q <= 1'b0;
			first_q <= 1'b0;
			nack_q <= 1'b0;
			o_sda_oe <= 1'b0;
			o_ptr <= 8'h00;
			o_wr <= 1'b0;
			o_wr_byte <= '0;
		end else begin
			scl_q <= i_scl;
			sda_q <= i_sda;
			o_wr <= 1'b0;
			if (stop_ev) begin // stop releases the line
				state_q <= S_IDLE;
				o_sda_oe <= 1'b0;
			end else if (start_ev) begin // start or repeated start
				state_q <= S_ADDR;
				cnt_q <= 4'h0;
				first_q <= 1'b1;
				o_sda_oe <= 1'b0;
			end else begin
				case (state_q)
					S_ADDR, S_WRB: begin
						if (rise_ev) begin // sample on rising scl
							sh_q <= {sh_q[6:0], i_sda};
							cnt_q <= cnt_q + 4'd1;
						end
						if (byte_end) begin
							cnt_q <= 4'h0;
							if (state_q == S_ADDR) begin
								rw_q <= sh_q[0];
								state_q <= addr_hit ? S_ACK : S_IDLE;
								o_sda_oe <= addr_hit;
							end else begin
								state_q <= S_ACK;
								o_sda_oe <= 1'b1;
								first_q <= 1'b0;
								if (first_q) begin // pointer byte
									o_ptr <= sh_q;
								end else begin // data byte, pointer walks up
									o_wr <= 1'b1;
									o_wr_byte <= '{addr: o_ptr, data: sh_q};
									o_ptr <= o_ptr + 8'd1;
								end
							end
						end
					end
					S_ACK: begin
						if (fall_ev) begin
							if (rw_q) begin // first read byte, msb first
								sh_q <= i_rd_data;
								o_sda_oe <= ~i_rd_data[7];
								state_q <= S_RDB;
							end else begin
								o_sda_oe <= 1'b0;
								state_q <= S_WRB;
							end
						end
					end
					S_RDB: begin
						if (rise_ev)
							cnt_q <= cnt_q + 4'd1;
						if (byte_end) begin // release for master ack
							o_sda_oe <= 1'b0;
							o_ptr <= o_ptr + 8'd1;
							state_q <= S_MACK;
						end else if (fall_ev) begin
							sh_q <= {sh_q[6:0], 1'b0};
							o_sda_oe <= ~sh_q[6];
						end
					end
					S_MACK: begin
						if (rise_ev)
							nack_q <= i_sda;
						if (fall_ev) begin
							cnt_q <= 4'h0;
							state_q <= nack_q ? S_IDLE : S_RDB;
							sh_q <= i_rd_data;
							o_sda_oe <= ~nack_q & ~i_rd_data[7];
						end
					end
					default: state_q <= S_IDLE;
				endcase
			end
		end
	end
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	addr_ack_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == S_ADDR && byte_end && !start_ev && !stop_ev && addr_hit)
		|=> (o_sda_oe && state_q == S_ACK))
		else $error("matching address not acknowledged");
endmodule : i2c_byte_target

/* File: verilog/host_power_boot_policy.sv */
// host power policy: thresholds, auto boot modes, wake timer, off delay
// assumes adc readings, touch, minute and tick pulses synchronous to clock
`timescale 1ns/1ps
module host_power_boot_policy #(
	parameter int REG_VERSION = 3,  // register set version 1..3
	parameter int ADC_W       = 10  // adc reading width
) (
	input  wire logic                I_CLOCK,
	input  wire logic                I_RST,
	input  wire logic                I_SCL,
	input  wire logic                I_SDA,
	output logic                     O_SDA,
	output logic                     O_SDA_OE,
	input  wire logic [ADC_W-1:0]    I_VBAT_RAW,
	input  wire logic [ADC_W-1:0]    I_OUTPUT_VOLTAGE_READING_RAW,
	input  wire logic                I_TOUCH,
	input  wire logic                I_HOST_TX,
	input  wire logic                I_SYS_TICK,
	input  wire logic                I_MINUTE,
	output logic                     O_HOST_POWER,
	output logic                     O_RUN_STATE
);
	import power_policy_pkg::*;
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {P_OFF, P_ON, P_DELAY} pwr_state_t;
	pwr_state_t  state_q;          // host power phase
	// one array so the bus and the policy read the same copy
	logic [15:0] regs_q [7];       // settings, indexed by reg_id_t
	logic [7:0]  lo_q;             // low byte waiting for its pair
	logic [15:0] tick_cnt_q;       // ticks since host shutdown
	logic        low_off_q;        // last power-off was low voltage
	logic        fire_q;           // wake timer expired
	logic        tx_q;             // transmit line one cycle ago
	logic        run_q;            // host run-state indication
	logic [7:0]  ptr;              // target byte pointer
	logic        wr;               // byte write strobe
	byte_wr_t    wr_byte;          // byte write address and data
	// ----------------------------------------------------------------
	// address decode per register set version
	// ----------------------------------------------------------------
	// map a byte address to a setting and the half of it
	// both bytes of a pair share one even base address
	function automatic reg_sel_t decode(input logic [7:0] a);
		reg_id_t id;
		id = R_NONE;
		case ({a[7:1], 1'b0})
			OFS_SHDN:   id = R_SHDN;
			OFS_BOOT:   id = R_BOOT;
			OFS_VMAX:   id = R_VMAX;
			default:    id = R_NONE;
		endcase
		// older sets place the mode and wake settings lower down
		if (REG_VERSION >= 3) begin
			if ({a[7:1], 1'b0} == OFS_ADC_OFS) id = R_ADC_OFS;
			if ({a[7:1], 1'b0} == OFS_DELAY)   id = R_DELAY;
			if ({a[7:1], 1'b0} == OFS_AUTO)    id = R_AUTO;
			if ({a[7:1], 1'b0} == OFS_WAKE)    id = R_WAKE;
		end else if (REG_VERSION == 2) begin
			if ({a[7:1], 1'b0} == OFS_DELAY_V2) id = R_DELAY;
			if ({a[7:1], 1'b0} == OFS_AUTO_V2)  id = R_AUTO;
			if ({a[7:1], 1'b0} == OFS_WAKE_V2)  id = R_WAKE;
		end else begin
			if ({a[7:1], 1'b0} == OFS_AUTO_V1) id = R_AUTO;
			if ({a[7:1], 1'b0} == OFS_WAKE_V1) id = R_WAKE;
		end
		// the one-byte mode setting has no upper byte
		if (id == R_AUTO && a[0]) id = R_NONE;
		return '{id: id, hi: a[0]};
	endfunction : decode
	// reset value of each setting
	// indices follow the order of reg_id_t
	function automatic logic [15:0] rst_val(input int i);
		case (i)
			0:       return RST_SHDN;
			1:       return RST_BOOT;
			2:       return RST_VMAX;
			3:       return RST_ADC_OFS;
			4:       return RST_DELAY;
			5:       return RST_AUTO;
			default: return RST_WAKE;
		endcase
	endfunction : rst_val
	// ----------------------------------------------------------------
	// bus target
	// ----------------------------------------------------------------
	reg_sel_t    rd_sel;
	reg_sel_t    wr_sel;
	logic [15:0] rd_word;
	logic [7:0]  rd_byte;
	assign rd_sel  = decode(ptr);
	assign wr_sel  = decode(wr_byte.addr);
	// reads are live: a pair that changes between its two byte
	// reads can tear, so software reads twice where that matters
	assign rd_word = (rd_sel.id == R_NONE) ? 16'h0000 : regs_q[rd_sel.id];
	// low byte at even address, high at odd
	assign rd_byte = rd_sel.hi ? rd_word[15:8] : rd_word[7:0];
	assign O_SDA   = 1'b0; // open drain, only ever pulls low

	// the bus address is fixed, no setting can move it
	i2c_byte_target u_target (
		.i_clk     (I_CLOCK),
		.i_rst     (I_RST),
		.i_dev_addr(RST_DEV_ADDR),
		.i_scl     (I_SCL),
		.i_sda     (I_SDA),
		.o_sda_oe  (O_SDA_OE),
		.o_ptr     (ptr),
		.i_rd_data (rd_byte),
		.o_wr      (wr),
		.o_wr_byte (wr_byte)
	);
	// ----------------------------------------------------------------
	// corrected readings and comparisons
	// ----------------------------------------------------------------
	logic [15:0] vbat_c;   // corrected battery reading
	logic [15:0] output_voltage_reading_c;   // corrected output reading
	logic        vbat_ok;  // battery may boot the host
	logic        output_voltage_reading_hi;  // output fed from another source
	logic        low_batt; // battery under shutdown threshold
	logic        tx_fall;  // host shut down
	logic        auto_go;  // an automatic mode wants power
	logic        boot_req; // every condition for power-on met
	logic        cut_now;  // delay has elapsed
	// offset is two's complement so it can trim either way
	// a trim below zero on a tiny reading wraps to a large value;
	// keep the offset small against real readings
	assign vbat_c   = 16'(I_VBAT_RAW) + regs_q[R_ADC_OFS];
	assign output_voltage_reading_c   = 16'(I_OUTPUT_VOLTAGE_READING_RAW) + regs_q[R_ADC_OFS];
	assign vbat_ok  = vbat_c >= regs_q[R_BOOT];
	assign output_voltage_reading_hi  = output_voltage_reading_c >= regs_q[R_VMAX];
	assign low_batt = vbat_c < regs_q[R_SHDN];
	assign tx_fall  = tx_q & ~I_HOST_TX;
	assign auto_go  = (regs_q[R_AUTO][7:0] == AUTO_VBAT)
		| ((regs_q[R_AUTO][7:0] == AUTO_SMART) & low_off_q);
	// touch stays honoured while the wake timer runs
	assign boot_req = vbat_ok & ~output_voltage_reading_hi & (I_TOUCH | auto_go | fire_q);
	assign cut_now  = tick_cnt_q >= regs_q[R_DELAY];
	// ----------------------------------------------------------------
	// settings, wake countdown
	// ----------------------------------------------------------------
	// one writer for the array: host writes win, countdown otherwise
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			for (int i = 0; i < 7; i++)
				regs_q[i] <= rst_val(i);
			lo_q <= 8'h00;
			fire_q <= 1'b0;
		end else begin
			if (wr && wr_sel.id != R_NONE) begin
				if (wr_sel.id == R_AUTO) // single byte setting
					regs_q[R_AUTO] <= {8'h00, wr_byte.data};
				else if (!wr_sel.hi)
					lo_q <= wr_byte.data; // held until the pair is complete
				else
					regs_q[wr_sel.id] <= {wr_byte.data, lo_q};
				if (wr_sel.id == R_WAKE)
					fire_q <= 1'b0; // a fresh setting rearms the timer
			end
			// a minute meeting a wake write is dropped, the new value wins
			if (state_q == P_OFF && I_MINUTE && regs_q[R_WAKE] != 16'h0000
				&& !(wr && wr_sel.id == R_WAKE)) begin
				regs_q[R_WAKE] <= regs_q[R_WAKE] - 16'd1;
				if (regs_q[R_WAKE] == 16'd1)
					fire_q <= 1'b1; // zero never reaches here
			end
			// counting stops once powered, so minutes left stay readable
			if (state_q == P_OFF && boot_req)
				fire_q <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// power sequencing
	// ----------------------------------------------------------------
	// one machine owns power, run state and the off delay
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			state_q <= P_OFF;
			tick_cnt_q <= 16'h0000;
			low_off_q <= 1'b0;
			tx_q <= 1'b0;
			run_q <= 1'b0;
			O_HOST_POWER <= 1'b0;
		end else begin
			tx_q <= I_HOST_TX;
			case (state_q)
				P_OFF: begin
					if (boot_req) begin
						state_q <= P_ON;
						O_HOST_POWER <= 1'b1;
						run_q <= 1'b1;
					end
				end
				P_ON: begin
					if (tx_fall) begin // host halted, start counting
						state_q <= P_DELAY;
						tick_cnt_q <= 16'h0000;
					end
					// low battery outranks touch so the cause stays low-voltage
					if (low_batt) begin // ask host to shut down
						run_q <= 1'b0;
						low_off_q <= 1'b1;
					end else if (I_TOUCH) begin // touch request, no smart-mode boot after
						run_q <= 1'b0;
						low_off_q <= 1'b0;
					end
				end
				P_DELAY: begin
					// ticks are slow and loose, so the delay is only a rough time
					if (cut_now) begin
						state_q <= P_OFF;
						O_HOST_POWER <= 1'b0;
						run_q <= 1'b0;
					end else if (I_SYS_TICK) begin
						tick_cnt_q <= tick_cnt_q + 16'd1;
					end
				end
				default: state_q <= P_OFF;
			endcase
		end
	end
	// the host daemon starts its own shutdown when this drops
	assign O_RUN_STATE = run_q;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);

	boot_needs_vbat_a: assert property ($rose(O_HOST_POWER) |-> $past(vbat_ok))
		else $error("powered up below boot threshold");
	output_voltage_reading_blocks_a: assert property ((state_q == P_OFF && output_voltage_reading_hi) |=> !O_HOST_POWER)
		else $error("powered up with external supply present");
	mode_zero_off_a: assert property (
		(state_q == P_OFF && regs_q[R_AUTO] == 16'h0 && !I_TOUCH && !fire_q)
		|=> !O_HOST_POWER)
		else $error("mode zero booted without touch");
	mode_one_boot_a: assert property (
		(state_q == P_OFF && regs_q[R_AUTO] == 16'h1 && vbat_ok && !output_voltage_reading_hi)
		|=> O_HOST_POWER)
		else $error("mode one did not boot");
	smart_gate_a: assert property (
		(state_q == P_OFF && regs_q[R_AUTO] == 16'h2 && !low_off_q && !I_TOUCH && !fire_q)
		|=> !O_HOST_POWER)
		else $error("smart mode booted after user off");
	wake_fire_a: assert property ($rose(fire_q) |-> $past(regs_q[R_WAKE]) == 16'd1)
		else $error("wake fired from wrong count");
	wake_hold_a: assert property ((state_q != P_OFF && !wr) |=> $stable(regs_q[R_WAKE]))
		else $error("wake minutes changed while on");
	tx_fall_a: assert property ((state_q == P_ON && tx_fall) |=> state_q == P_DELAY
		&& tick_cnt_q == 16'h0)
		else $error("shutdown edge missed");
	delay_cut_a: assert property ((state_q == P_DELAY && cut_now) |=> !O_HOST_POWER)
		else $error("power not cut after delay");
	delay_early_a: assert property ($fell(O_HOST_POWER) |-> $past(cut_now))
		else $error("power cut before delay");
	low_run_a: assert property ((state_q == P_ON && low_batt) |=> !O_RUN_STATE)
		else $error("run state kept on low battery");
	pair_commit_a: assert property ((wr && !wr_sel.hi && wr_sel.id == R_BOOT)
		|=> $stable(regs_q[R_BOOT]))
		else $error("threshold changed on half write");
	// ----------------------------------------------------------------
	// policy invariants
	// ----------------------------------------------------------------
	power_state_a: assert property (O_HOST_POWER == (state_q != P_OFF))
		else $error("power output out of step with state");
	run_needs_power_a: assert property (O_RUN_STATE |-> O_HOST_POWER)
		else $error("run state high without power");
	low_vbat_a: assert property ((state_q == P_OFF && !vbat_ok) |=> !O_HOST_POWER)
		else $error("powered up on low battery");
	auto_write_a: assert property ((wr && wr_sel.id == R_AUTO)
		|=> regs_q[R_AUTO] == {8'h00, $past(wr_byte.data)})
		else $error("mode setting not stored");
	pair_write_a: assert property ((wr && wr_sel.hi && wr_sel.id == R_BOOT)
		|=> regs_q[R_BOOT] == {$past(wr_byte.data), $past(lo_q)})
		else $error("threshold pair not committed");

	// wake timer
	wake_step_a: assert property ((state_q == P_OFF && I_MINUTE && !wr
		&& regs_q[R_WAKE] != 16'h0) |=> regs_q[R_WAKE] == $past(regs_q[R_WAKE]) - 16'd1)
		else $error("wake minutes not counted down");
	wake_off_a: assert property ((regs_q[R_WAKE] == 16'h0 && !fire_q) |=> !fire_q)
		else $error("zero wake setting fired");
	fire_clear_a: assert property ((state_q == P_OFF && boot_req) |=> !fire_q)
		else $error("wake fire kept after boot");

	// shutdown path
	low_cause_a: assert property ((state_q == P_ON && low_batt) |=> low_off_q)
		else $error("low battery cause not kept");
	touch_off_a: assert property ((state_q == P_ON && I_TOUCH && !low_batt)
		|=> !O_RUN_STATE && !low_off_q)
		else $error("touch off not recorded");
	tick_step_a: assert property ((state_q == P_DELAY && !cut_now && I_SYS_TICK)
		|=> tick_cnt_q == $past(tick_cnt_q) + 16'd1)
		else $error("tick not counted");
	tick_hold_a: assert property ((state_q == P_DELAY && !I_SYS_TICK)
		|=> $stable(tick_cnt_q))
		else $error("tick count moved without tick");

	// scenarios the bench should reach
	boot_cov: cover property ($rose(O_HOST_POWER));
	cut_cov: cover property ($fell(O_HOST_POWER));
	wake_cov: cover property ($rose(fire_q) ##1 O_HOST_POWER);
	smart_cov: cover property (low_off_q && $rose(O_HOST_POWER));
	delay_cov: cover property (state_q == P_DELAY && I_SYS_TICK);
endmodule : host_power_boot_policy

/* File: tb/host_i2c_master.sv */
// host model: i2c master with open-drain data, plus the host serial tx line
// assumes the device output enable pulls the data wire low, pull-up otherwise
`timescale 1ns/1ps
module host_i2c_master (
	input  wire logic i_clk,     // core clock, paces every bus phase
	input  wire logic i_sda_oe,  // device pulls data low
	output logic      o_scl,     // bus clock, idles high
	output logic      o_sda,     // resolved data wire
	output logic      o_host_tx  // serial tx of the host
);
	// ------------------------------------------------------------
	// wire resolution and pacing
	// ------------------------------------------------------------
	logic sda_q = 1'b1;               // own drive, 1 = released
	initial o_scl = 1'b1;
	initial o_host_tx = 1'b1;         // running host holds tx high
	assign o_sda = sda_q & ~i_sda_oe; // pull-up level unless someone pulls

	// all changes land just after an edge, never on it
	task automatic wt(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : wt

	// host shutdown shows as a falling tx line
	task automatic set_tx(input logic v);
		o_host_tx = v;
	endtask : set_tx

	// start (a=0) or stop (a=1): data moves while the clock is high
	task automatic cond(input logic a);
		sda_q = ~a;
		wt(2);
		o_scl = 1'b1;
		wt(4);
		sda_q = a;
		wt(4);
		o_scl = a;
		wt(1);
	endtask : cond

	// one bit, four clocks per phase; wire sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		sda_q = b;
		wt(4);
		o_scl = 1'b1;
		wt(2);
		r = o_sda;
		wt(2);
		o_scl = 1'b0;
	endtask : bit_io

	// eight data bits then the ninth: r[0] is the ack slot level
	task automatic byte_io(input logic [7:0] d, input logic last, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
			bit_io(i ? d[i-1] : last, r[i]);
	endtask : byte_io

	// address, pointer, then n data bytes low first; ok only if all acked
	task automatic wr(input logic [7:0] dev, input logic [7:0] ofs, input logic [15:0] v,
		input int n, input logic keep, output logic ok);
		logic [31:0] s;
		logic [8:0]  r;
		s = {v, ofs, dev};
		ok = 1'b1;
		cond(1'b0);
		for (int k = 0; k < n + 2; k++) begin
			byte_io(s[8*k +: 8], 1'b1, r);
			ok &= ~r[0];
		end
		if (!keep)
			cond(1'b1);
	endtask : wr

	// pointer write, repeated start, two bytes read, nack on the last
	task automatic rd(input logic [7:0] ofs, output logic [15:0] v);
		logic       ok;
		logic [8:0] r;
		wr(8'h86, ofs, 16'h0000, 0, 1'b1, ok);
		cond(1'b0);
		byte_io(8'h87, 1'b1, r);
		byte_io(8'hff, 1'b0, r);
		v[7:0] = r[8:1];
		byte_io(8'hff, 1'b1, r);
		v[15:8] = r[8:1];
		cond(1'b1);
	endtask : rd
endmodule : host_i2c_master

/* File: tb/tb_host_power_boot_policy.sv */
// self-checking bench for the host power policy block
// assumes register set version 3 and the host model on the i2c side
`timescale 1ns/1ps
module tb_host_power_boot_policy;
	import power_policy_pkg::*;
	logic       clk = 1'b0;   // 50 MHz core clock
	logic       rst = 1'b1;   // async reset
	logic [9:0] vbat = 10'h0; // battery reading
	logic [9:0] output_voltage_reading = 10'h0; // output reading
	logic [2:0] ev = 3'h0;    // touch, tick, minute pulses
	logic       scl, sda, oe, tx, pwr, run, sdo;
	int         fail_count = 0;
	int         tests_run = 0;
	always #10 clk = ~clk;

	host_i2c_master host_i2c_master_inst (.i_clk(clk), .i_sda_oe(oe), .o_scl(scl),
		.o_sda(sda), .o_host_tx(tx));
	host_power_boot_policy host_power_boot_policy_inst (.I_CLOCK(clk), .I_RST(rst),
		.I_SCL(scl), .I_SDA(sda), .O_SDA(sdo), .O_SDA_OE(oe), .I_VBAT_RAW(vbat),
		.I_OUTPUT_VOLTAGE_READING_RAW(output_voltage_reading), .I_TOUCH(ev[0]), .I_HOST_TX(tx), .I_SYS_TICK(ev[1]),
		.I_MINUTE(ev[2]), .O_HOST_POWER(pwr), .O_RUN_STATE(run));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic st(input logic [1:0] e);
		chk({14'h0, pwr, run}, {14'h0, e});
	endtask : st
	// one-cycle pulse; k picks touch, tick or minute
	task automatic pls(input int k);
		ev = 3'h1 << k;
		wt(1);
		ev = 3'h0;
		wt(2);
	endtask : pls
	task automatic wr(input logic [7:0] ofs, input logic [15:0] v, input int n);
		logic ok;
		host_i2c_master_inst.wr(8'h86, ofs, v, n, 1'b0, ok);
		chk({15'h0, ok}, 16'h1);
	endtask : wr
	task automatic rdc(input logic [7:0] ofs, input logic [15:0] e);
		logic [15:0] v;
		host_i2c_master_inst.rd(ofs, v);
		chk(v, e);
	endtask : rdc
	// tx falls, delay of two ticks; one tick is not yet enough
	task automatic off_host;
		host_i2c_master_inst.set_tx(1'b0);
		wt(3);
		pls(1);
		chk({15'h0, pwr}, 16'h1);
		pls(1);
		chk({15'h0, pwr}, 16'h0);
		host_i2c_master_inst.set_tx(1'b1);
	endtask : off_host

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		logic [7:0]  o [7] = '{OFS_BOOT, OFS_VMAX, OFS_ADC_OFS, OFS_DELAY, OFS_AUTO, OFS_WAKE, 8'h1e};
		logic [15:0] e [7] = '{16'h0285, 16'h02cd, 16'h0, 16'h0041, 16'h0, 16'h0, 16'h0};
		logic        ok;
		for (int i = 0; i < 7; i++)
			rdc(o[i], e[i]);
		host_i2c_master_inst.wr(8'h88, OFS_AUTO, 16'h0001, 1, 1'b0, ok);
		chk({15'h0, ok}, 16'h0);
		rdc(OFS_AUTO, 16'h0);
		chk({15'h0, sdo}, 16'h0);
	endtask : t_regs
	task automatic t_touch;
		vbat = 10'h2c0;
		wt(40);
		st(2'b00);
		pls(0);
		st(2'b11);
		wr(OFS_DELAY, 16'h0002, 2);
		off_host();
	endtask : t_touch
	task automatic t_boot;
		wr(OFS_BOOT, 16'h0300, 2);
		rdc(OFS_BOOT, 16'h0300);
		vbat = 10'h2ff;
		pls(0);
		st(2'b00);
		wr(OFS_BOOT, 16'h00ff, 1);
		rdc(OFS_BOOT, 16'h0300);
		vbat = 10'h290;
		pls(0);
		st(2'b00);
		vbat = 10'h300;
		pls(0);
		st(2'b11);
		off_host();
	endtask : t_boot
	task automatic t_limit;
		output_voltage_reading = 10'h2cd;
		pls(0);
		st(2'b00);
		output_voltage_reading = 10'h2cc;
		pls(0);
		st(2'b11);
		off_host();
		output_voltage_reading = 10'h0;
		vbat = 10'h2fb;
		wr(OFS_ADC_OFS, 16'h0004, 2);
		pls(0);
		st(2'b00);
		wr(OFS_ADC_OFS, 16'h0005, 2);
		pls(0);
		st(2'b11);
		off_host();
		wr(OFS_ADC_OFS, 16'h0, 2);
	endtask : t_limit
	task automatic t_auto;
		vbat = 10'h300;
		wr(OFS_AUTO, 16'h0001, 1);
		st(2'b11);
		vbat = 10'h250;
		wt(2);
		st(2'b10);
		off_host();
		wr(OFS_AUTO, 16'h0002, 1);
		vbat = 10'h300;
		wt(2);
		st(2'b11);
		pls(0);
		off_host();
		wt(20);
		st(2'b00);
		wr(OFS_AUTO, 16'h0, 1);
	endtask : t_auto
	task automatic t_wake;
		wr(OFS_WAKE, 16'h0003, 2);
		pls(2);
		pls(2);
		st(2'b00);
		pls(2);
		st(2'b11);
		rdc(OFS_WAKE, 16'h0);
		off_host();
		for (int i = 0; i < 3; i++)
			pls(2);
		st(2'b00);
		wr(OFS_WAKE, 16'h0005, 2);
		pls(2);
		pls(0);
		st(2'b11);
		rdc(OFS_WAKE, 16'h0004);
	endtask : t_wake

	task automatic end_of_test;
		if (fail_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// main sequence: reset for 16 clocks, then every scenario in turn
	initial begin
		wt(16);
		rst = 1'b0;
		wt(2);
		t_regs();
		t_touch();
		t_boot();
		t_limit();
		t_auto();
		t_wake();
		end_of_test();
	end
	// watchdog: the run needs well under a quarter of this span
	initial begin
		#1000000;
		fail_count++;
		end_of_test();
	end
endmodule : tb_host_power_boot_policy
